// file: core/pwtsr_top.sv
// pulse-width qualified trigger driving segmented replay of sample memory
// assumes a single sample clock; trigger pins are asynchronous to it
`timescale 1ns/1ns
`include "pwtsr_consts.svh"
module pwtsr_top import pwtsr_pkg::*; (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // parameter port
  input  wire logic [15:0] param_addr,
  input  wire logic        param_wr,
  input  wire logic        param_rd,
  input  wire logic [63:0] param_wdata,
  output logic      [63:0] param_rdata,
  output logic             param_rvalid,
  // trigger pins
  input  wire logic        ext_trig_in,
  input  wire logic        aux_trig_in,
  // replay datapath
  output logic      [63:0] rep_addr,
  output logic             rep_valid,
  output logic             rep_seg_start,
  // status
  output logic             run_active,
  output logic             trig_armed
);

  function automatic pwtsr_qual_t qual_of(input logic [31:0] m);
    case (m)
      `PWT_MODE_HI_LONG:  qual_of = Q_HI_LONG;
      `PWT_MODE_HI_SHORT: qual_of = Q_HI_SHORT;
      `PWT_MODE_LO_LONG:  qual_of = Q_LO_LONG;
      `PWT_MODE_LO_SHORT: qual_of = Q_LO_SHORT;
      default:            qual_of = Q_NONE;
    endcase
  endfunction

  logic [63:0]  seg_len_r;
  logic [63:0]  mem_size_r;
  logic [31:0]  loops_r;
  logic [31:0]  mode_r;
  logic [31:0]  ormask_r;
  logic [31:0]  cardmode_r;
  logic [15:0]  thr_r;
  logic [2:0]   ext_s_r;
  logic [2:0]   aux_s_r;
  logic [15:0]  cnt_r;
  pwtsr_state_t st_r;
  logic [63:0]  base_r;
  logic [63:0]  pos_r;
  logic [31:0]  segs_r;
  logic [2:0]   rearm_r;
  logic [63:0]  rdata_r;
  logic         rvalid_r;
  logic [63:0]  addr_r;
  logic         valid_r;
  logic         segst_r;

  logic         wr_cmd_c;
  logic         start_c;
  logic         stop_c;
  logic         sw_c;
  pwtsr_qual_t  qsel_c;
  logic         hi_pol_c;
  logic         at_lvl_c;
  logic         pend_c;
  logic         ext_hit_c;
  logic         aux_hit_c;
  logic         multi_c;
  logic         fifo_c;
  logic         trig_c;
  logic         seg_end_c;
  logic [63:0]  next_base_c;
  logic         wrap_c;
  logic         last_c;

  assign wr_cmd_c = param_wr && (param_addr == `PWT_OFS_CMD);
  assign start_c  = wr_cmd_c && param_wdata[`PWT_CMD_START];
  assign stop_c   = wr_cmd_c && param_wdata[`PWT_CMD_STOP];
  assign sw_c     = wr_cmd_c && param_wdata[`PWT_CMD_SWTRIG];

  // parameter writes; threshold below the floor is lifted to it
  always_ff @(posedge clk) begin
    if (rst) begin
      seg_len_r  <= `PWT_SEG_RST;
      mem_size_r <= `PWT_MEM_RST;
      loops_r    <= 32'h00000000;
      mode_r     <= 32'h00000000;
      ormask_r   <= 32'h00000000;
      cardmode_r <= `PWT_CM_STD_MULTI;
      thr_r      <= `PWT_THR_RST;
    end else if (param_wr) begin
      case (param_addr)
        `PWT_OFS_SEGLEN:   seg_len_r  <= param_wdata; // RL12
        `PWT_OFS_MEMSIZE:  mem_size_r <= param_wdata;
        `PWT_OFS_LOOPS:    loops_r    <= param_wdata[31:0];
        `PWT_OFS_MODE:     mode_r     <= param_wdata[31:0];
        `PWT_OFS_ORMASK:   ormask_r   <= param_wdata[31:0];
        `PWT_OFS_CARDMODE: cardmode_r <= param_wdata[31:0];
        `PWT_OFS_THR: begin
          if (param_wdata[15:0] < `PWT_THR_MIN) begin
            thr_r <= `PWT_THR_MIN; // RL5
          end else begin
            thr_r <= param_wdata[15:0]; // RL5
          end
        end
        default: ;
      endcase
    end
  end

  // reads answer one cycle later; unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r  <= 64'h0000000000000000;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= param_rd;
      if (param_rd) begin
        case (param_addr)
          `PWT_OFS_SEGLEN:   rdata_r <= seg_len_r;
          `PWT_OFS_MEMSIZE:  rdata_r <= mem_size_r;
          `PWT_OFS_LOOPS:    rdata_r <= {32'h00000000, loops_r};
          `PWT_OFS_MODE:     rdata_r <= {32'h00000000, mode_r};
          `PWT_OFS_ORMASK:   rdata_r <= {32'h00000000, ormask_r};
          `PWT_OFS_CARDMODE: rdata_r <= {32'h00000000, cardmode_r};
          `PWT_OFS_THR:      rdata_r <= {48'h000000000000, thr_r};
          `PWT_OFS_CAP:      rdata_r <= {48'h000000000000, `PWT_THR_MAX}; // RL7
          `PWT_OFS_STATUS:   rdata_r <= {segs_r, 30'h00000000, st_r};
          default:           rdata_r <= 64'h0000000000000000;
        endcase
      end
    end
  end

  // two-stage synchronisers; the third stage serves edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_s_r <= 3'h0;
      aux_s_r <= 3'h0;
    end else begin
      ext_s_r <= {ext_s_r[1:0], ext_trig_in}; // RL17
      aux_s_r <= {aux_s_r[1:0], aux_trig_in}; // RL17
    end
  end

  assign qsel_c   = qual_of(mode_r);
  assign hi_pol_c = (qsel_c == Q_HI_LONG) || (qsel_c == Q_HI_SHORT);
  assign at_lvl_c = hi_pol_c ? ext_s_r[1] : !ext_s_r[1];
  assign pend_c   = (hi_pol_c ? ext_s_r[2] : !ext_s_r[2]) && !at_lvl_c;

  // width counter saturates at 65535, so very long pulses still read as long for thresholds below 65535
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 16'h0000;
    end else if (!at_lvl_c) begin
      cnt_r <= 16'h0000;
    end else if (cnt_r != `PWT_THR_MAX) begin
      cnt_r <= cnt_r + 16'h0001; // RL16
    end
  end

  always_comb begin
    ext_hit_c = 1'b0;
    if (pend_c) begin
      case (qsel_c)
        Q_HI_LONG:  ext_hit_c = cnt_r > thr_r; // RL1
        Q_HI_SHORT: ext_hit_c = cnt_r < thr_r; // RL2
        Q_LO_LONG:  ext_hit_c = cnt_r > thr_r; // RL3
        Q_LO_SHORT: ext_hit_c = cnt_r < thr_r; // RL4
        default:    ext_hit_c = 1'b0;
      endcase
    end
  end

  assign aux_hit_c = aux_s_r[1] && !aux_s_r[2];
  assign fifo_c    = cardmode_r == `PWT_CM_FIFO_MULTI;
  assign multi_c   = fifo_c || (cardmode_r == `PWT_CM_STD_MULTI);
  assign trig_c    = (ormask_r[`PWT_MASK_EXT0] && ext_hit_c)
                  || (ormask_r[`PWT_MASK_AUX] && aux_hit_c)
                  || (sw_c && !multi_c); // RL13

  assign seg_end_c   = (pos_r + 64'h1) >= seg_len_r;
  assign next_base_c = base_r + seg_len_r;
  assign wrap_c      = next_base_c >= mem_size_r;
  // a single loop in stored mode means one pass over all of memory
  assign last_c = (loops_r != 32'h00000000) &&
                  ((!fifo_c && loops_r == 32'h00000001) ? wrap_c
                                                        : (segs_r + 32'h1) == loops_r); // RL14

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r    <= ST_IDLE;
      base_r  <= 64'h0000000000000000;
      pos_r   <= 64'h0000000000000000;
      segs_r  <= 32'h00000000;
      rearm_r <= 3'h0;
    end else if (stop_c) begin
      st_r <= ST_IDLE;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (start_c) begin
            st_r   <= ST_ARMED;
            base_r <= 64'h0000000000000000;
            segs_r <= 32'h00000000;
          end
        end
        ST_ARMED: begin
          if (trig_c) begin
            st_r  <= ST_PLAY; // RL6
            pos_r <= 64'h0000000000000000;
          end
        end
        ST_PLAY: begin
          pos_r <= pos_r + 64'h1;
          if (seg_end_c) begin
            segs_r  <= segs_r + 32'h1;
            base_r  <= wrap_c ? 64'h0000000000000000 : next_base_c; // RL9
            rearm_r <= 3'(`PWT_REARM_CYC - 1);
            st_r    <= last_c ? ST_IDLE : ST_REARM; // RL10
          end
        end
        ST_REARM: begin
          if (rearm_r == 3'h0) begin
            st_r <= ST_ARMED; // RL11
          end else begin
            rearm_r <= rearm_r - 3'h1;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_r  <= 64'h0000000000000000;
      valid_r <= 1'b0;
      segst_r <= 1'b0;
    end else begin
      valid_r <= (st_r == ST_PLAY) && !stop_c; // RL9
      segst_r <= (st_r == ST_PLAY) && !stop_c && (pos_r == 64'h0);
      addr_r  <= base_r + pos_r;
    end
  end

  assign param_rdata   = rdata_r;
  assign param_rvalid  = rvalid_r;
  assign rep_addr      = addr_r;
  assign rep_valid     = valid_r;
  assign rep_seg_start = segst_r;

  logic run_r;
  logic arm_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      run_r <= 1'b0;
      arm_r <= 1'b0;
    end else begin
      run_r <= (st_r != ST_IDLE) && !stop_c;
      arm_r <= (st_r == ST_ARMED) && !stop_c && !trig_c;
    end
  end
  assign run_active = run_r;
  assign trig_armed = arm_r;

  // checking helpers
  logic [63:0] vcnt_r;
  logic        cut_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      vcnt_r <= 64'h0;
      cut_r  <= 1'b0;
    end else begin
      vcnt_r <= valid_r ? vcnt_r + 64'h1 : 64'h0;
      cut_r  <= stop_c ? 1'b1 : ((st_r == ST_ARMED) ? 1'b0 : cut_r);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_hi_long_width: assert property (ext_hit_c && qsel_c == Q_HI_LONG |-> // RL1
    ext_s_r[2] && !ext_s_r[1] && cnt_r > thr_r) else $error("long high pulse qualifier");
  a_hi_short_width: assert property (ext_hit_c && qsel_c == Q_HI_SHORT |-> // RL2
    ext_s_r[2] && !ext_s_r[1] && cnt_r < thr_r) else $error("short high pulse qualifier");
  a_lo_long_width: assert property (ext_hit_c && qsel_c == Q_LO_LONG |-> // RL3
    !ext_s_r[2] && ext_s_r[1] && cnt_r > thr_r) else $error("long low pulse qualifier");
  a_lo_short_width: assert property (ext_hit_c && qsel_c == Q_LO_SHORT |-> // RL4
    !ext_s_r[2] && ext_s_r[1] && cnt_r < thr_r) else $error("short low pulse qualifier");
  a_thr_range: assert property (thr_r >= `PWT_THR_MIN) // RL5
    else $error("threshold below floor");
  a_trig_once: assert property (st_r == ST_ARMED && trig_c && !stop_c |=> // RL6
    !arm_r ##1 valid_r && rep_seg_start) else $error("accepted trigger did not start segment");
  a_cap_read: assert property (param_rd && param_addr == `PWT_OFS_CAP |=> // RL7
    param_rvalid && param_rdata == 64'h000000000000ffff) else $error("capability readback");
  // when valid_r has just fallen, the helper count already holds the full segment
  a_seg_len: assert property ($fell(valid_r) && !cut_r |-> // RL12
    vcnt_r == seg_len_r) else $error("segment length mismatch");
  a_rearm_time: assert property ($rose(st_r == ST_REARM) |-> // RL11
    (st_r == ST_REARM || stop_c) ##[1:4] st_r != ST_REARM) else $error("re-arm delay");
  a_no_swtrig: assert property (multi_c && sw_c && !ext_hit_c && !aux_hit_c && !stop_c // RL13
    && st_r == ST_ARMED |=> st_r == ST_ARMED) else $error("software trigger accepted");
  a_loop_stop: assert property (st_r == ST_PLAY && seg_end_c && loops_r > 32'h1 // RL14
    && segs_r + 32'h1 == loops_r && !stop_c |=> st_r == ST_IDLE) else $error("loop count stop");

  c_ext_trig: cover property (ext_hit_c && st_r == ST_ARMED);
  c_rearm_seg: cover property (st_r == ST_REARM ##[1:8] st_r == ST_ARMED);
  c_wrap: cover property (st_r == ST_PLAY && seg_end_c && wrap_c);
  c_auto_stop: cover property (st_r == ST_PLAY && seg_end_c && last_c);

endmodule

// file: include/pwtsr_consts.svh
// constants of the pulse-width trigger and segment replay block
// assumes a 125 MHz sample clock and the parameter port of pwtsr_top
//
// Behaviour
// [RL1] mode 4000001h: trigger only on high pulses longer than the width threshold
// [RL2] mode 2000001h: trigger only on high pulses shorter than the threshold
// [RL3] mode 4000002h: trigger only on low pulses longer than the threshold
// [RL4] mode 2000002h: trigger only on low pulses shorter than the threshold
// [RL5] width threshold is read/write in samples, valid range 2 to 65535
// [RL6] first matching pulse triggers; none more until replay ends and block re-arms
// [RL7] read-only parameter reports the largest supported width threshold
// [RL8] software selects mode, sets threshold and enables external input in or-mask
// [RL9] multi replay splits memory into equal segments, one segment per trigger
// [RL10] successive segments need no software restart
// [RL11] after a segment, hardware re-arms after a short fixed delay
// [RL12] segment length register gives samples output per trigger
// [RL13] multi replay accepts every trigger source except the software trigger
// [RL14] loops 0 runs forever, 1 plays memory once, N plays N segments then stops; in fifo multi the code plays one segment for loops 1
// [RL15] software sets total memory size to a multiple of segment size
// [RL16] width counted while input at level; equal to threshold matches no mode
// [RL17] external input synchronised before edge detection or width measurement
`ifndef PWTSR_CONSTS_SVH
`define PWTSR_CONSTS_SVH
`define PWT_OFS_CARDMODE 16'h251c
`define PWT_OFS_MEMSIZE  16'h2710
`define PWT_OFS_SEGLEN   16'h271a
`define PWT_OFS_LOOPS    16'h2724
`define PWT_OFS_ORMASK   16'h9dd0
`define PWT_OFS_MODE     16'h9e3e
`define PWT_OFS_CAP      16'haca8
`define PWT_OFS_THR      16'hacb2
`define PWT_OFS_CMD      16'h0064
`define PWT_OFS_STATUS   16'h006e
`define PWT_MODE_HI_LONG  32'h04000001
`define PWT_MODE_HI_SHORT 32'h02000001
`define PWT_MODE_LO_LONG  32'h04000002
`define PWT_MODE_LO_SHORT 32'h02000002
`define PWT_CM_STD_MULTI  32'h00000200
`define PWT_CM_FIFO_MULTI 32'h00001000
`define PWT_MASK_AUX   0
`define PWT_MASK_EXT0  1
`define PWT_CMD_START  0
`define PWT_CMD_STOP   1
`define PWT_CMD_SWTRIG 2
`define PWT_THR_MIN   16'h0002
`define PWT_THR_MAX   16'hffff
`define PWT_THR_RST   16'h0002
`define PWT_SEG_RST   64'h0000000000000400
`define PWT_MEM_RST   64'h0000000000001000
`define PWT_CLK_NS    8
`define PWT_REARM_NS  32
`define PWT_REARM_CYC ((`PWT_REARM_NS + `PWT_CLK_NS - 1) / `PWT_CLK_NS)
`endif

// file: include/pwtsr_pkg.sv
// types of the pulse-width trigger and segment replay block
// assumes pwtsr_consts.svh is included by the design file
package pwtsr_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_PLAY, ST_REARM} pwtsr_state_t;
  typedef enum logic [2:0] {Q_NONE, Q_HI_LONG, Q_HI_SHORT, Q_LO_LONG, Q_LO_SHORT} pwtsr_qual_t;
endpackage

// file: testbench/pwtsr_trig_src.sv
// external ttl trigger source that drives the pulse-width input
// assumes the bench calls its tasks and that the pin is sampled on clk
`timescale 1ns/1ns
module pwtsr_trig_src (
  // clock
  input  wire logic clk,
  // trigger pin
  output logic      ext_trig_in
);
  initial ext_trig_in = 1'b0;

  // a ttl line is always driven: between pulses it rests at the inverse level
  task automatic rest_for(input logic lvl);
    @(posedge clk);
    ext_trig_in <= ~lvl;
  endtask

  task automatic pulse(input logic lvl, input int w, input int gap);
    @(posedge clk);
    ext_trig_in <= lvl;
    repeat (w) @(posedge clk);
    ext_trig_in <= ~lvl;
    repeat (gap) @(posedge clk);
  endtask
endmodule

// file: testbench/tb.sv
// self-checking bench of the pulse-width trigger and segment replay block
// assumes the parameter port contract of pwtsr_top and a 125 MHz clock
`timescale 1ns/1ns
`include "pwtsr_consts.svh"
module tb;
  logic        clk;
  logic        rst;
  logic [15:0] param_addr;
  logic        param_wr;
  logic        param_rd;
  logic [63:0] param_wdata;
  logic [63:0] param_rdata;
  logic        param_rvalid;
  logic        ext_trig_in;
  logic        aux_trig_in;
  logic [63:0] rep_addr;
  logic        rep_valid;
  logic        rep_seg_start;
  logic        run_active;
  logic        trig_armed;
  int          failures;
  int          num_checks;
  logic [63:0] exp_base;
  localparam logic [63:0] SEG = 64'h3;
  localparam logic [63:0] MEM = 64'h9;

  always #4 clk = ~clk;

  pwtsr_top u_pwtsr_top (
    .clk(clk), .rst(rst), .param_addr(param_addr), .param_wr(param_wr),
    .param_rd(param_rd), .param_wdata(param_wdata), .param_rdata(param_rdata),
    .param_rvalid(param_rvalid), .ext_trig_in(ext_trig_in), .aux_trig_in(aux_trig_in),
    .rep_addr(rep_addr), .rep_valid(rep_valid), .rep_seg_start(rep_seg_start),
    .run_active(run_active), .trig_armed(trig_armed)
  );
  pwtsr_trig_src u_pwtsr_trig_src (.clk(clk), .ext_trig_in(ext_trig_in));

  task automatic summarize();
    if (failures == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic timeout(input string name);
    failures++;
    $display("BAD %s expected done seen timeout", name);
    summarize();
  endtask

  task automatic wr(input logic [15:0] a, input logic [63:0] d);
    @(posedge clk);
    param_wr    <= 1'b1;
    param_addr  <= a;
    param_wdata <= d;
    @(posedge clk);
    param_wr <= 1'b0;
  endtask

  // read data is looked at in the one cycle that rvalid stands
  task automatic rd_chk(input string name, input logic [15:0] a, input logic [63:0] exp);
    @(posedge clk);
    param_rd   <= 1'b1;
    param_addr <= a;
    @(posedge clk);
    param_rd <= 1'b0;
    #1;
    chk("read valid", 64'h1, {63'h0, param_rvalid});
    chk(name, exp, param_rdata);
  endtask

  task automatic expect_none(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      chk("idle replay", 64'h0, {63'h0, rep_valid});
    end
  endtask

  task automatic aux_edge();
    @(posedge clk);
    aux_trig_in <= 1'b1;
    repeat (2) @(posedge clk);
    aux_trig_in <= 1'b0;
  endtask

  // follows one segment; the last segment of a counted run does not re-arm
  task automatic seg_check(input logic rearm);
    int i;
    i = 0;
    while (rep_seg_start !== 1'b1) begin
      @(posedge clk);
      #1;
      i++;
      if (i > 40) timeout("segment start");
    end
    i = 0;
    while (rep_valid === 1'b1 && i < 100) begin
      chk("replay address", exp_base + 64'(i), rep_addr);
      i++;
      @(posedge clk);
      #1;
    end
    chk("segment length", SEG, 64'(i));
    exp_base = (exp_base + SEG >= MEM) ? 64'h0 : exp_base + SEG;
    i = 0;
    while (rearm && trig_armed !== 1'b1) begin
      @(posedge clk);
      #1;
      i++;
      if (i > 10) timeout("re-arm");
    end
  endtask

  task automatic regs_scn();
    rd_chk("capability", `PWT_OFS_CAP, 64'hffff);
    rd_chk("threshold reset", `PWT_OFS_THR, 64'h2);
    rd_chk("segment reset", `PWT_OFS_SEGLEN, `PWT_SEG_RST);
    rd_chk("unmapped", 16'h1234, 64'h0);
    wr(`PWT_OFS_CAP, 64'h55);
    rd_chk("capability ro", `PWT_OFS_CAP, 64'hffff);
    wr(`PWT_OFS_THR, 64'h1);
    rd_chk("threshold low", `PWT_OFS_THR, 64'h2);
    wr(`PWT_OFS_THR, 64'hffff);
    rd_chk("threshold max", `PWT_OFS_THR, 64'hffff);
  endtask

  task automatic setup_scn();
    wr(`PWT_OFS_CARDMODE, {32'h0, `PWT_CM_STD_MULTI});
    wr(`PWT_OFS_SEGLEN, SEG);
    wr(`PWT_OFS_MEMSIZE, MEM);
    wr(`PWT_OFS_LOOPS, 64'h0);
    wr(`PWT_OFS_THR, 64'h8);
    wr(`PWT_OFS_ORMASK, 64'h3);
    wr(`PWT_OFS_CMD, 64'h1);
    exp_base = 64'h0;
  endtask

  // widths 4 and 12 sit well clear of threshold 8; a width of exactly 8 matches no mode
  task automatic modes_scn();
    logic [31:0] words [4];
    logic        lvl;
    int          good;
    words = '{`PWT_MODE_HI_LONG, `PWT_MODE_HI_SHORT, `PWT_MODE_LO_LONG, `PWT_MODE_LO_SHORT};
    for (int m = 0; m < 4; m++) begin
      lvl = (m < 2);
      good = (m % 2 == 0) ? 12 : 4;
      wr(`PWT_OFS_MODE, 64'h0);
      u_pwtsr_trig_src.rest_for(lvl);
      wr(`PWT_OFS_MODE, {32'h0, words[m]});
      u_pwtsr_trig_src.pulse(lvl, 16 - good, 0);
      u_pwtsr_trig_src.pulse(lvl, 8, 0);
      expect_none(20);
      fork
        begin
          u_pwtsr_trig_src.pulse(lvl, good, 1);
          u_pwtsr_trig_src.pulse(lvl, 4, 0);
        end
        seg_check(1'b1);
      join
      expect_none(20);
    end
    chk("still running", 64'h1, {63'h0, run_active});
  endtask

  task automatic swtrig_scn();
    wr(`PWT_OFS_MODE, 64'h0);
    wr(`PWT_OFS_CMD, 64'h4);
    expect_none(20);
    fork
      aux_edge();
      seg_check(1'b1);
    join
  endtask

  task automatic loops_scn();
    logic [63:0] lp [2];
    int          nseg [2];
    int          t;
    lp = '{64'h1, 64'h2};
    nseg = '{3, 2};
    for (int k = 0; k < 2; k++) begin
      wr(`PWT_OFS_CMD, 64'h2);
      wr(`PWT_OFS_LOOPS, lp[k]);
      wr(`PWT_OFS_CMD, 64'h1);
      exp_base = 64'h0;
      for (int s = 0; s < nseg[k]; s++) begin
        fork
          aux_edge();
          seg_check(s < nseg[k] - 1);
        join
      end
      t = 0;
      while (run_active !== 1'b0) begin
        @(posedge clk);
        #1;
        t++;
        if (t > 10) timeout("run stop");
      end
      aux_edge();
      expect_none(20);
    end
  endtask

  // fifo multi with one loop plays one segment; outside multi replay software triggers count
  task automatic fifo_scn();
    wr(`PWT_OFS_CMD, 64'h2);
    wr(`PWT_OFS_CARDMODE, {32'h0, `PWT_CM_FIFO_MULTI});
    wr(`PWT_OFS_LOOPS, 64'h1);
    wr(`PWT_OFS_CMD, 64'h1);
    exp_base = 64'h0;
    fork
      aux_edge();
      seg_check(1'b0);
    join
    chk("fifo run stop", 64'h0, {63'h0, run_active});
    wr(`PWT_OFS_CARDMODE, 64'h0);
    wr(`PWT_OFS_LOOPS, 64'h0);
    wr(`PWT_OFS_CMD, 64'h1);
    exp_base = 64'h0;
    fork
      wr(`PWT_OFS_CMD, 64'h4);
      seg_check(1'b1);
    join
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    param_addr = 16'h0;
    param_wr = 1'b0;
    param_rd = 1'b0;
    param_wdata = 64'h0;
    aux_trig_in = 1'b0;
    failures = 0;
    num_checks = 0;
    exp_base = 64'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    regs_scn();
    setup_scn();
    modes_scn();
    swtrig_scn();
    loops_scn();
    fifo_scn();
    summarize();
  end
endmodule
